/* File: core/rdsa_cal_if.sv */
// Calendar view shared between the top and the rule comparators
`timescale 1ns/10ps
interface rdsa_cal_if;
	logic [7:0] hours;
	logic [7:0] month;
	logic [2:0] weekday;
	logic [2:0] week_count;
	logic last_week;

	modport src
	(
		output hours,
		output month,
		output weekday,
		output week_count,
		output last_week
	);
	modport cmp
	(
		input hours,
		input month,
		input weekday,
		input week_count,
		input last_week
	);
endinterface : rdsa_cal_if

/* File: core/rdsa_pkg.sv */
// Constants and types for the daylight-saving adjustment block
// Overview of operation
// - With saving enabled, a spring rule match adds one extra hour increment.
// - With saving enabled, a fall rule match suppresses the hour increment once.
// - After a fall adjustment, the rule stays disarmed one hour, then re-arms itself.
// - Week-of-month is kept internally; field 1..4 is that week, 5 is last week.
// - Weekday field bits 10:8 compare against weekday counter bits 2:0.
// - Month field in the low byte compares against the month counter.
// - Hour bits 30:24 compare hours 6:0; bit 31 compares AM/PM if 12-hour written.
// - Hour and month use format captured at write; later mode changes keep them.
// - Every field matches exactly; software loads valid values while saving is on.
// - Rule registers accept whole-word writes and single-byte writes.
// - The skipped hour never exists, so an alarm inside it cannot fire.
// - The repeated hour runs twice, so an alarm inside it fires twice.
package rdsa_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_SPRING = 8'h18;
	localparam logic [7:0] OFF_FALL = 8'h1c;
	localparam logic [7:0] OFF_CTRL = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [31:0] RULE_RESET = 32'h0000_0000;
	localparam logic [31:0] RULE_WMASK = 32'hff07_07ff;
	localparam int MERIDIEM_BIT = 31;
	localparam int HOUR_LSB = 24;
	localparam int WEEK_LSB = 16;
	localparam int WDAY_LSB = 8;
	localparam int MONTH_LSB = 0;
	localparam int CTRL_DSE_BIT = 0;
	localparam int CTRL_BIN_BIT = 1;
	localparam int CTRL_H12_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [2:0] WEEK_LAST = 3'h5;
	localparam logic [4:0] DAYS_PER_WEEK = 5'h07;

	typedef enum logic [1:0]
	{
		FB_ARMED = 2'b01,
		FB_SPENT = 2'b10
	} rdsa_fall_t;

	typedef struct packed
	{
		logic [31:0] spring_rule;
		logic [31:0] fall_rule;
		logic spring_h12;
		logic fall_h12;
		logic spring_bin;
		logic fall_bin;
		logic daylight_saving_enable;
		logic binary_format_select;
		logic hour12_mode;
		rdsa_fall_t fall_state;
		logic [31:0] rdata;
	} rdsa_state_t;
endpackage : rdsa_pkg

/* File: core/rdsa_rule_match.sv */
// Exact comparison of one rule word against the running calendar
`timescale 1ns/10ps
module rdsa_rule_match
(
	// Calendar
	rdsa_cal_if.cmp cal,
	// Rule
	input wire logic [31:0] rule_word,
	input wire logic use_meridiem,
	// Result
	output logic hit
);
	logic [2:0] week_f;
	logic week_ok;
	logic hour_ok;
	logic mer_ok;
	logic wday_ok;
	logic month_ok;

	always_comb
	begin
		week_f = rule_word[rdsa_pkg::WEEK_LSB +: 3];
		// Week 5 is the last occurrence, 1..4 the counted week
		if (week_f == rdsa_pkg::WEEK_LAST)
		begin
			week_ok = cal.last_week;
		end
		else
		begin
			week_ok = (week_f == cal.week_count);
		end
		hour_ok = (rule_word[rdsa_pkg::HOUR_LSB +: 7] == cal.hours[6:0]);
		mer_ok = !use_meridiem
			|| (rule_word[rdsa_pkg::MERIDIEM_BIT] == cal.hours[7]);
		wday_ok = (rule_word[rdsa_pkg::WDAY_LSB +: 3] == cal.weekday);
		month_ok = (rule_word[rdsa_pkg::MONTH_LSB +: 8] == cal.month);
		// No field value acts as a wildcard
		hit = week_ok && hour_ok && mer_ok && wday_ok && month_ok;
	end
endmodule : rdsa_rule_match

/* File: core/rdsa_top.sv */
// Daylight-saving adjustment: rule registers, week tracking and hour steering
`timescale 1ns/10ps
module rdsa_top
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [rdsa_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Calendar counters
	input wire logic [7:0] hours_value,
	input wire logic [7:0] month_value,
	input wire logic [7:0] weekday_value,
	input wire logic [4:0] day_of_month,
	input wire logic [4:0] month_length,
	input wire logic hour_tick,
	// Hour steering
	output logic hour_advance,
	output logic hour_hold
);
	rdsa_pkg::rdsa_state_t st_reg;
	rdsa_pkg::rdsa_state_t st_next;
	rdsa_cal_if cal ();
	logic spring_hit;
	logic fall_hit;
	logic [2:0] week_count;
	logic last_week;
	logic [4:0] days_left;
	logic sel_spring;
	logic sel_fall;
	logic sel_ctrl;
	logic sel_status;
	logic [31:0] be_mask;
	logic [31:0] status_word;

	// Week of month from the day of month
	always_comb
	begin
		if (day_of_month <= 5'd7)
		begin
			week_count = 3'd1;
		end
		else if (day_of_month <= 5'd14)
		begin
			week_count = 3'd2;
		end
		else if (day_of_month <= 5'd21)
		begin
			week_count = 3'd3;
		end
		else if (day_of_month <= 5'd28)
		begin
			week_count = 3'd4;
		end
		else
		begin
			week_count = 3'd5;
		end
		// Last week: no further same weekday fits in this month
		days_left = month_length - day_of_month;
		last_week = (month_length >= day_of_month)
			&& (days_left < rdsa_pkg::DAYS_PER_WEEK);
	end

	assign cal.hours = hours_value;
	assign cal.month = month_value;
	assign cal.weekday = weekday_value[2:0];
	assign cal.week_count = week_count;
	assign cal.last_week = last_week;

	rdsa_rule_match u_spring
	(
		.cal(cal.cmp),
		.rule_word(st_reg.spring_rule),
		.use_meridiem(st_reg.spring_h12),
		.hit(spring_hit)
	);

	rdsa_rule_match u_fall
	(
		.cal(cal.cmp),
		.rule_word(st_reg.fall_rule),
		.use_meridiem(st_reg.fall_h12),
		.hit(fall_hit)
	);

	// Extra increment makes the following hour never occur
	assign hour_advance = hour_tick && st_reg.daylight_saving_enable
		&& spring_hit;
	// Inhibited increment makes the current hour run a second time
	assign hour_hold = hour_tick && st_reg.daylight_saving_enable && fall_hit
		&& (st_reg.fall_state == rdsa_pkg::FB_ARMED);

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			be_mask[i*8 +: 8] = {8{reg_be[i]}};
		end
	end

	assign sel_spring = (reg_addr == rdsa_pkg::OFF_SPRING);
	assign sel_fall = (reg_addr == rdsa_pkg::OFF_FALL);
	assign sel_ctrl = (reg_addr == rdsa_pkg::OFF_CTRL);
	assign sel_status = (reg_addr == rdsa_pkg::OFF_STATUS);

	assign status_word = {23'h00_0000, st_reg.fall_h12, st_reg.spring_h12, st_reg.fall_bin,
		st_reg.spring_bin, last_week, week_count,
		st_reg.fall_state == rdsa_pkg::FB_ARMED};

	always_comb
	begin
		st_next = st_reg;
		// Byte lanes write independently; reserved bits stay zero
		if (reg_wr && sel_spring)
		begin
			st_next.spring_rule = ((st_reg.spring_rule & ~be_mask)
				| (reg_wdata & be_mask)) & rdsa_pkg::RULE_WMASK;
			// Format of hour and month is frozen when those bytes are written
			if (reg_be[3])
			begin
				st_next.spring_h12 = st_reg.hour12_mode;
			end
			if (reg_be[3] || reg_be[0])
			begin
				st_next.spring_bin = st_reg.binary_format_select;
			end
		end
		if (reg_wr && sel_fall)
		begin
			st_next.fall_rule = ((st_reg.fall_rule & ~be_mask)
				| (reg_wdata & be_mask)) & rdsa_pkg::RULE_WMASK;
			if (reg_be[3])
			begin
				st_next.fall_h12 = st_reg.hour12_mode;
			end
			if (reg_be[3] || reg_be[0])
			begin
				st_next.fall_bin = st_reg.binary_format_select;
			end
		end
		if (reg_wr && sel_ctrl && reg_be[0])
		begin
			st_next.daylight_saving_enable = reg_wdata[rdsa_pkg::CTRL_DSE_BIT];
			st_next.binary_format_select = reg_wdata[rdsa_pkg::CTRL_BIN_BIT];
			st_next.hour12_mode = reg_wdata[rdsa_pkg::CTRL_H12_BIT];
		end
		// Fall rule disarm across the repeated hour, then self re-arm
		unique case (st_reg.fall_state)
			rdsa_pkg::FB_ARMED:
			begin
				if (hour_hold)
				begin
					st_next.fall_state = rdsa_pkg::FB_SPENT;
				end
			end
			rdsa_pkg::FB_SPENT:
			begin
				if (hour_tick || !st_reg.daylight_saving_enable)
				begin
					st_next.fall_state = rdsa_pkg::FB_ARMED;
				end
			end
			default:
			begin
				st_next.fall_state = rdsa_pkg::FB_ARMED;
			end
		endcase
		// Read data for one cycle after the strobe; unmapped reads give zero
		st_next.rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			if (sel_spring)
			begin
				st_next.rdata = st_reg.spring_rule;
			end
			else if (sel_fall)
			begin
				st_next.rdata = st_reg.fall_rule;
			end
			else if (sel_ctrl)
			begin
				st_next.rdata = {29'h0000_0000, st_reg.hour12_mode,
					st_reg.binary_format_select, st_reg.daylight_saving_enable};
			end
			else if (sel_status)
			begin
				st_next.rdata = status_word;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_reg.spring_rule <= rdsa_pkg::RULE_RESET;
			st_reg.fall_rule <= rdsa_pkg::RULE_RESET;
			st_reg.spring_h12 <= 1'b0;
			st_reg.fall_h12 <= 1'b0;
			st_reg.spring_bin <= 1'b0;
			st_reg.fall_bin <= 1'b0;
			st_reg.daylight_saving_enable <= rdsa_pkg::CTRL_RESET[0];
			st_reg.binary_format_select <= rdsa_pkg::CTRL_RESET[1];
			st_reg.hour12_mode <= rdsa_pkg::CTRL_RESET[2];
			st_reg.fall_state <= rdsa_pkg::FB_ARMED;
			st_reg.rdata <= 32'h0000_0000;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
endmodule : rdsa_top

/* File: tb/rdsa_checker.sv */
// Port checker for the daylight-saving block
`timescale 1ns/10ps
module rdsa_checker
(
	// Watched ports
	input wire logic clk,
	input wire logic rstn,
	input wire logic [rdsa_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic hour_tick,
	input wire logic hour_advance,
	input wire logic hour_hold
);
	logic en_reg;
	logic spent_reg;
	logic ctl;
	logic off;
	assign ctl = reg_wr && reg_addr == 8'h20 && reg_be[0];
	assign off = ctl && !reg_wdata[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			en_reg <= 1'b0;
			spent_reg <= 1'b0;
		end
		else
		begin
			if (ctl)
				en_reg <= reg_wdata[0];
			spent_reg <= hour_hold || (spent_reg && !hour_tick && !off);
		end
	end
	sequence s_put;
		reg_wr && reg_be == 4'hf && (reg_addr == 8'h18 || reg_addr == 8'h1c);
	endsequence
	sequence s_gap;
		!reg_wr && !reg_rd && $stable(reg_addr);
	endsequence
	sequence s_get;
		reg_rd && $stable(reg_addr);
	endsequence
	a_read_rest: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside answer cycle");
	a_spare_zero: assert property ($past(reg_rd) |-> (reg_rdata & 32'h00f8_f800) == 32'h0)
		else $error("reserved bits read nonzero");
	a_hole_zero: assert property ($past(reg_rd) && !($past(reg_addr) inside
		{8'h18, 8'h1c, 8'h20, 8'h24}) |-> reg_rdata == 32'h0)
		else $error("unmapped read nonzero");
	a_word_back: assert property (s_put ##1 s_gap ##1 s_get |=>
		reg_rdata == ($past(reg_wdata, 3) & 32'hff07_07ff))
		else $error("rule word readback wrong");
	a_spring_gate: assert property (hour_advance |-> hour_tick && en_reg)
		else $error("advance without tick or enable");
	a_fall_gate: assert property (hour_hold |-> hour_tick && en_reg && !spent_reg)
		else $error("hold without tick, enable or arming");
	a_off_quiet: assert property ($past(off) |-> !hour_advance && !hour_hold)
		else $error("steering after disable");
	a_spent_tick: assert property (hour_hold ##2 hour_tick |-> !hour_hold)
		else $error("repeated hour held twice");
endmodule : rdsa_checker
bind rdsa_top rdsa_checker u_chk
(
	.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hour_tick(hour_tick),
	.hour_advance(hour_advance), .hour_hold(hour_hold)
);

/* File: tb/rtc_daylight_saving_adjust_tb_top.sv */
// Self-checking bench for the daylight-saving block
`timescale 1ns/10ps
module rtc_daylight_saving_adjust_tb_top;
	logic clk = 0;
	logic rstn = 0;
	logic [7:0] a = 0;
	logic [31:0] wd = 0;
	logic [31:0] rdat;
	logic [3:0] be = 0;
	logic wr = 0;
	logic rd = 0;
	logic tk = 0;
	logic adv;
	logic hld;
	logic [7:0] hr = 0;
	logic [7:0] mo = 0;
	logic [7:0] dw = 0;
	logic [4:0] dom = 1;
	logic [4:0] ml = 31;
	logic [31:0] lf = 32'h4835_0f25;
	logic [31:0] rul [2] = '{32'h0, 32'h0};
	logic h12c [2] = '{1'b0, 1'b0};
	logic h12 = 0;
	logic bin = 0;
	logic binc [2] = '{1'b0, 1'b0};
	logic en = 0;
	logic arm = 1;
	int n_errors = 0;
	int check_count = 0;
	rdsa_top dut
	(
		.clk(clk), .rstn(rstn), .reg_addr(a), .reg_wdata(wd), .reg_be(be), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdat), .hours_value(hr), .month_value(mo),
		.weekday_value(dw), .day_of_month(dom), .month_length(ml), .hour_tick(tk),
		.hour_advance(adv), .hour_hold(hld)
	);
	initial
	begin
		forever #2 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	function automatic logic mt(input int k);
		logic [31:0] r;
		logic [2:0] w;
		r = rul[k];
		w = (dom > 28) ? 3'h5 : 3'((dom - 1) / 7 + 1);
		if (r[18:16] == 3'h5)
			w = (ml - dom < 7) ? 3'h5 : 3'h0;
		return hr[6:0] == r[30:24] && (!h12c[k] || hr[7] == r[31]) && mo == r[7:0]
			&& dw[2:0] == r[10:8] && w == r[18:16];
	endfunction : mt
	function automatic logic [3:0] wl();
		logic [2:0] w;
		w = (dom > 28) ? 3'h5 : 3'((dom - 1) / 7 + 1);
		return {ml >= dom && ml - dom < 7, w};
	endfunction : wl
	task automatic wrt(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] b);
		logic [31:0] m;
		m = d & 32'hff07_07ff;
		@(posedge clk);
		a <= ad;
		wd <= d;
		be <= b;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		for (int i = 0; i < 4; i++)
			if (b[i] && (ad == 8'h18 || ad == 8'h1c))
				rul[ad[2]][8*i+:8] = m[8*i+:8];
		if (b[3] && (ad == 8'h18 || ad == 8'h1c))
			h12c[ad[2]] = h12;
		if ((b[3] || b[0]) && (ad == 8'h18 || ad == 8'h1c))
			binc[ad[2]] = bin;
		if (ad == 8'h20 && b[0])
		begin
			en = d[0];
			bin = d[1];
			h12 = d[2];
			arm = arm | !d[0];
		end
	endtask : wrt
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
		@(posedge clk);
		a <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdat, e);
	endtask : rdc
	task automatic tick();
		logic [31:0] r;
		logic [4:0] m;
		logic ea;
		logic eh;
		lf = nx(lf);
		r = rul[lf[0]];
		m = 5'h1c + 5'(lf[12:11]);
		@(posedge clk);
		hr <= {lf[9], lf[3:2] != 0 ? r[30:24] : lf[16:10]};
		mo <= lf[5:4] != 0 ? r[7:0] : lf[24:17];
		dw <= {lf[31:27], lf[7:6] != 0 ? r[10:8] : lf[26:24]};
		ml <= m;
		dom <= (lf[14:13] != 0 && r[18:16] < 5) ?
			5'(r[18:16] * 7 - 6 + lf[22:20] % 7) : 5'(lf[22:18] % m + 1);
		tk <= 1'b1;
		@(negedge clk);
		ea = en && mt(0);
		eh = en && arm && mt(1);
		chk(adv, ea);
		chk(hld, eh);
		arm = !eh;
		@(posedge clk);
		tk <= 1'b0;
	endtask : tick
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rdc(8'h18, 32'h0);
		rdc(8'h1c, 32'h0);
		rdc(8'h20, 32'h0);
		wrt(8'h30, 32'hffff_ffff, 4'hf);
		rdc(8'h30, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			lf = nx(lf);
			wrt({5'h03, lf[0], 2'h0}, lf, lf[13:10] | {4{i < 4}});
			rdc({5'h03, lf[0], 2'h0}, rul[lf[0]]);
		end
		for (int p = 0; p < 2; p++)
		begin
			wrt(8'h20, {29'h0, p[0], !p[0], 1'b0}, 4'h1);
			for (int k = 0; k < 2; k++)
			begin
				lf = nx(lf);
				wrt(k ? 8'h1c : 8'h18, {lf[31:19], 3'(lf[18:16] % 5 + 1), lf[15:0]}, 4'hf);
			end
			wrt(8'h20, 32'h1, 4'h1);
			rdc(8'h20, 32'h1);
			rdc(8'h24, {23'h0, h12c[1], h12c[0], binc[1], binc[0], wl(), arm});
			for (int i = 0; i < 200; i++)
			begin
				if (lf[31:28] == 0)
					wrt(8'h20, {31'h0, !en}, 4'h1);
				tick();
			end
		end
		wrap_up();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
endmodule : rtc_daylight_saving_adjust_tb_top
